/* File: verilog/bpsr_pkg.sv */
// Purpose: shared constants for the primary error status register
// Assumes: 16-bit configuration word at a byte offset, one core clock
// Notes:   flag index order is fixed by bpsr_flag_pos, low index first
package bpsr_pkg;

	// configuration access geometry
	localparam int          BPSR_ADDR_W        = 8;
	localparam int          BPSR_DATA_W        = 16;
	localparam int          BPSR_BE_W          = 2;
	localparam int          BPSR_LANE_W        = 8;
	localparam logic [7:0]  BPSR_STATUS_OFFSET = 8'h06;

	// reset value; bit 4 (capability list present) is the only one set
	localparam logic [15:0] BPSR_STATUS_RESET  = 16'h0010;
	// fixed image of the read-only bits: capability list present, rest zero
	localparam logic [15:0] BPSR_STATUS_CONST  = 16'h0010;
	// mask of bits that must always read as zero (10:9, 7:5, 3:0)
	localparam logic [15:0] BPSR_ZERO_MASK     = 16'h06ef;
	localparam int          BPSR_CAP_LIST_POS  = 4;

	// sticky event flags
	localparam int          BPSR_FLAG_COUNT    = 6;
	localparam int          FLG_DATA_POISON    = 0;
	localparam int          FLG_SIG_CA         = 1;
	localparam int          FLG_RX_CA          = 2;
	localparam int          FLG_RX_UR          = 3;
	localparam int          FLG_SIGNALLED_SYSTEM_ERROR_FLAG        = 4;
	localparam int          FLG_DET_POISON     = 5;

	// bit position of each flag inside the status word, by flag index
	localparam int          BPSR_FLAG_POS [BPSR_FLAG_COUNT] = '{8, 11, 12, 13, 14, 15};

	typedef logic [BPSR_DATA_W-1:0]     bpsr_word_t;
	typedef logic [BPSR_FLAG_COUNT-1:0] bpsr_flags_t;

endpackage

/* File: verilog/bpsr_flag_if.sv */
// Purpose: carries set, clear and state of the sticky flags
// Assumes: one clock domain shared by both ends
// Notes:   set and clear are single-cycle qualifiers, flags are levels
`timescale 1ns/100ps
interface bpsr_flag_if;
	import bpsr_pkg::*;

	bpsr_flags_t set;
	bpsr_flags_t clr;
	bpsr_flags_t flags;

	modport ctrl (output set, output clr, input flags);
	modport bank (input set, input clr, output flags);
endinterface

/* File: verilog/bpsr_flag_bank.sv */
// Purpose: bank of sticky event flags, set by hardware, cleared by software
// Assumes: set and clr arrive already qualified, same clock
// Notes:   set beats clear so an event in the clearing cycle survives
`timescale 1ns/100ps
module bpsr_flag_bank
	import bpsr_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// flag traffic
	bpsr_flag_if.bank fl
);

	genvar gi;
	generate
		for (gi = 0; gi < BPSR_FLAG_COUNT; gi++) begin : g_flag
			logic flag_q;
			logic flag_d;

			// next value: set wins over clear, writing zero holds
			always_comb begin
				flag_d = fl.set[gi] | (flag_q & ~fl.clr[gi]);
			end

			// register only
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					flag_q <= 1'b0;
				end else begin
					flag_q <= flag_d;
				end
			end

			assign fl.flags[gi] = flag_q;

			a_set_beats_clr: assert property (@(posedge clock) disable iff (!rst_b)
				(fl.set[gi] && fl.clr[gi]) |=> flag_q)
				else $error("flag lost when set and clear coincide");
		end
	endgenerate

endmodule // bpsr_flag_bank

/* File: verilog/bpsr_status_top.sv */
// Purpose: primary-side error status word of the bridge configuration header
// Assumes: event pulses and command enables come from core logic on clock
// Notes:   read data is registered, one cycle after the read strobe
//
// Behaviour
// - Poisoned TLP received sets bit 15, ungated
// - Sent fatal/nonfatal message with enable sets 14
// - Completion with unsupported request sets 13
// - Completion with completer abort sets 12
// - Returning completer abort completion sets 11
// - Bits 10:9 always read as 00b
// - Poisoned completion data sets 8 if parity enabled
// - Poisoning received write sets 8 if enabled
// - Bits 7 and 5 always read zero
// - Bit 4 always reads one
// - Bit 3 always reads zero
// - Bits 6 and 2:0 read zero
`timescale 1ns/100ps
module bpsr_status_top
	import bpsr_pkg::*;
(
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// configuration access from the upstream port
	input  wire logic                   cfg_rd_en,
	input  wire logic                   cfg_wr_en,
	input  wire logic [BPSR_ADDR_W-1:0] cfg_addr,
	input  wire logic [BPSR_DATA_W-1:0] cfg_wr_data,
	input  wire logic [BPSR_BE_W-1:0]   cfg_byte_en,
	output logic      [BPSR_DATA_W-1:0] cfg_rd_data_q,
	output logic                        cfg_rd_valid_q,
	// enables from the command register
	input  wire logic                   parity_response_enable,
	input  wire logic                   system_error_enable,
	// error events from the link core, one-cycle pulses
	input  wire logic                   poisoned_tlp_rx,
	input  wire logic                   err_msg_tx,
	input  wire logic                   cpl_ur_rx,
	input  wire logic                   cpl_ca_rx,
	input  wire logic                   cpl_ca_tx,
	input  wire logic                   cpl_poison_rx,
	input  wire logic                   write_poisoned,
	// live view of the status word
	output logic      [BPSR_DATA_W-1:0] status_word_q
);

	bpsr_flag_if flag_bus ();

	bpsr_word_t  image;
	bpsr_word_t  cfg_rd_data_d;
	logic        cfg_rd_valid_d;
	bpsr_word_t  status_word_d;
	logic        hit_status;
	bpsr_flags_t set_v;
	bpsr_flags_t clr_v;

	// the flag bank holds the only state that software can change
	bpsr_flag_bank u_flags (
		.clock (clock),
		.rst_b (rst_b),
		.fl    (flag_bus.bank)
	);

	// address decode; anything else reads zero and ignores writes
	always_comb begin
		if (cfg_addr == BPSR_STATUS_OFFSET) begin
			hit_status = 1'b1;
		end else begin
			hit_status = 1'b0;
		end
	end

	// hardware set events, each gated as its flag demands
	always_comb begin
		set_v                  = '0;
		set_v[FLG_DET_POISON]  = poisoned_tlp_rx;
		set_v[FLG_SIGNALLED_SYSTEM_ERROR_FLAG]     = err_msg_tx & system_error_enable;
		set_v[FLG_RX_UR]       = cpl_ur_rx;
		set_v[FLG_RX_CA]       = cpl_ca_rx;
		set_v[FLG_SIG_CA]      = cpl_ca_tx;
		set_v[FLG_DATA_POISON] = parity_response_enable
			& (cpl_poison_rx | write_poisoned);
	end

	// write-one-to-clear, honouring the byte lane that carries each flag
	always_comb begin
		clr_v = '0;
		for (int i = 0; i < BPSR_FLAG_COUNT; i++) begin
			clr_v[i] = cfg_wr_en & hit_status
				& cfg_wr_data[BPSR_FLAG_POS[i]]
				& cfg_byte_en[BPSR_FLAG_POS[i] / BPSR_LANE_W];
		end
	end

	assign flag_bus.set = set_v;
	assign flag_bus.clr = clr_v;

	// read image: fixed bits from the constant, flags dropped into place
	always_comb begin
		image = BPSR_STATUS_CONST;
		for (int i = 0; i < BPSR_FLAG_COUNT; i++) begin
			image[BPSR_FLAG_POS[i]] = flag_bus.flags[i];
		end
	end

	// read path next values; unmapped reads answer zero so nothing hangs
	always_comb begin
		cfg_rd_valid_d = cfg_rd_en;
		if (cfg_rd_en && hit_status) begin
			cfg_rd_data_d = image;
		end else if (cfg_rd_en) begin
			cfg_rd_data_d = '0;
		end else begin
			cfg_rd_data_d = cfg_rd_data_q;
		end
		status_word_d = image;
	end

	// register only; outputs leave straight from these flops
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rd_data_q  <= '0;
			cfg_rd_valid_q <= 1'b0;
			status_word_q  <= BPSR_STATUS_RESET;
		end else begin
			cfg_rd_data_q  <= cfg_rd_data_d;
			cfg_rd_valid_q <= cfg_rd_valid_d;
			status_word_q  <= status_word_d;
		end
	end

	// ------------------------------------------------------------------
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	logic det_poison_f;
	logic signalled_system_error_flag_f;
	logic rx_ur_f;
	logic rx_ca_f;
	logic sig_ca_f;
	logic data_poison_f;

	assign det_poison_f  = flag_bus.flags[FLG_DET_POISON];
	assign signalled_system_error_flag_f     = flag_bus.flags[FLG_SIGNALLED_SYSTEM_ERROR_FLAG];
	assign rx_ur_f       = flag_bus.flags[FLG_RX_UR];
	assign rx_ca_f       = flag_bus.flags[FLG_RX_CA];
	assign sig_ca_f      = flag_bus.flags[FLG_SIG_CA];
	assign data_poison_f = flag_bus.flags[FLG_DATA_POISON];

	// write-one requests rebuilt from the bus pins, so the checks do not lean on clr_v
	logic        wr_hit;
	bpsr_flags_t wr_one;

	assign wr_hit = cfg_wr_en && (cfg_addr == BPSR_STATUS_OFFSET);

	always_comb begin
		wr_one = '0;
		for (int i = 0; i < BPSR_FLAG_COUNT; i++) begin
			wr_one[i] = wr_hit && cfg_wr_data[BPSR_FLAG_POS[i]]
				&& cfg_byte_en[BPSR_FLAG_POS[i] / BPSR_LANE_W];
		end
	end

	a_poison_sets_det: assert property (
		poisoned_tlp_rx |=> det_poison_f ##1 status_word_q[BPSR_FLAG_POS[FLG_DET_POISON]])
		else $error("poisoned tlp did not set detected poison flag");

	a_signalled_system_error_flag_gated: assert property (
		err_msg_tx && system_error_enable |=> signalled_system_error_flag_f)
		else $error("error message with enable did not set system error flag");

	a_signalled_system_error_flag_blocked: assert property (
		!signalled_system_error_flag_f && !(err_msg_tx && system_error_enable) |=> !signalled_system_error_flag_f)
		else $error("system error flag set without enabled message");

	a_ur_sets_flag: assert property (
		cpl_ur_rx |=> rx_ur_f)
		else $error("unsupported request completion not recorded");

	a_ca_rx_sets: assert property (
		cpl_ca_rx |=> rx_ca_f)
		else $error("received completer abort not recorded");

	a_ca_tx_sets: assert property (
		cpl_ca_tx |=> sig_ca_f)
		else $error("signalled completer abort not recorded");

	a_data_poison_on: assert property (
		parity_response_enable && (cpl_poison_rx || write_poisoned) |=> data_poison_f)
		else $error("data poison flag missed with parity response enabled");

	a_data_poison_off: assert property (
		!data_poison_f && !parity_response_enable |=> !data_poison_f)
		else $error("data poison flag set while parity response disabled");

	a_fixed_bits_read: assert property (
		cfg_rd_valid_q |-> (cfg_rd_data_q & BPSR_ZERO_MASK) == 16'h0000)
		else $error("hardwired zero bit read as one");

	a_cap_list_one: assert property (
		cfg_rd_en && hit_status |=> cfg_rd_valid_q && cfg_rd_data_q[BPSR_CAP_LIST_POS])
		else $error("capability list bit did not read as one");

	a_clear_by_one: assert property (
		wr_one[FLG_SIG_CA] && !cpl_ca_tx
		|=> !sig_ca_f ##1 (!status_word_q[BPSR_FLAG_POS[FLG_SIG_CA]] || sig_ca_f))
		else $error("write one did not clear signalled abort flag");

	a_zero_write_keeps: assert property (
		rx_ur_f && !wr_one[FLG_RX_UR] |=> rx_ur_f)
		else $error("flag dropped without write one");

	a_set_wins_clear: assert property (
		cpl_ur_rx && wr_one[FLG_RX_UR]
		|=> rx_ur_f [*2] or (rx_ur_f ##1 $past(wr_one[FLG_RX_UR])))
		else $error("event lost in clearing cycle");

	// each flag drops on its own write-one unless an event lands in the same cycle
	a_det_clears: assert property (
		wr_one[FLG_DET_POISON] && !poisoned_tlp_rx |=> !det_poison_f)
		else $error("write one did not clear detected poison flag");

	a_sys_clears: assert property (
		wr_one[FLG_SIGNALLED_SYSTEM_ERROR_FLAG] && !(err_msg_tx && system_error_enable) |=> !signalled_system_error_flag_f)
		else $error("write one did not clear system error flag");

	a_ur_clears: assert property (
		wr_one[FLG_RX_UR] && !cpl_ur_rx |=> !rx_ur_f)
		else $error("write one did not clear unsupported request flag");

	a_ca_rx_clears: assert property (
		wr_one[FLG_RX_CA] && !cpl_ca_rx |=> !rx_ca_f)
		else $error("write one did not clear received abort flag");

	a_dp_clears: assert property (
		wr_one[FLG_DATA_POISON]
		&& !(parity_response_enable && (cpl_poison_rx || write_poisoned))
		|=> !data_poison_f)
		else $error("write one did not clear data poison flag");

	// a zero, a closed lane or another offset must leave a set flag alone
	a_det_keeps: assert property (
		det_poison_f && !wr_one[FLG_DET_POISON] |=> det_poison_f)
		else $error("detected poison flag dropped without write one");

	a_sys_keeps: assert property (
		signalled_system_error_flag_f && !wr_one[FLG_SIGNALLED_SYSTEM_ERROR_FLAG] |=> signalled_system_error_flag_f)
		else $error("system error flag dropped without write one");

	a_ca_rx_keeps: assert property (
		rx_ca_f && !wr_one[FLG_RX_CA] |=> rx_ca_f)
		else $error("received abort flag dropped without write one");

	a_ca_tx_keeps: assert property (
		sig_ca_f && !wr_one[FLG_SIG_CA] |=> sig_ca_f)
		else $error("signalled abort flag dropped without write one");

	a_dp_keeps: assert property (
		data_poison_f && !wr_one[FLG_DATA_POISON] |=> data_poison_f)
		else $error("data poison flag dropped without write one");

	// no flag rises without its own event
	a_det_quiet: assert property (
		!det_poison_f && !poisoned_tlp_rx |=> !det_poison_f)
		else $error("detected poison flag set without poisoned tlp");

	a_ur_quiet: assert property (
		!rx_ur_f && !cpl_ur_rx |=> !rx_ur_f)
		else $error("unsupported request flag set without completion");

	a_ca_rx_quiet: assert property (
		!rx_ca_f && !cpl_ca_rx |=> !rx_ca_f)
		else $error("received abort flag set without completion");

	a_ca_tx_quiet: assert property (
		!sig_ca_f && !cpl_ca_tx |=> !sig_ca_f)
		else $error("signalled abort flag set without completion sent");

	// the live word carries the fixed bits and follows the flags one cycle late
	a_live_zero_bits: assert property (
		(status_word_q & BPSR_ZERO_MASK) == 16'h0000)
		else $error("hardwired zero bit shows one in live word");

	a_live_cap_bit: assert property (
		status_word_q[BPSR_CAP_LIST_POS])
		else $error("capability list bit low in live word");

	a_live_tracks_ur: assert property (
		rx_ur_f |=> status_word_q[BPSR_FLAG_POS[FLG_RX_UR]])
		else $error("live word lost unsupported request flag");

	a_live_tracks_sys: assert property (
		signalled_system_error_flag_f |=> status_word_q[BPSR_FLAG_POS[FLG_SIGNALLED_SYSTEM_ERROR_FLAG]])
		else $error("live word lost system error flag");

	a_read_matches_live: assert property (
		cfg_rd_en && (cfg_addr == BPSR_STATUS_OFFSET) |=> cfg_rd_data_q == status_word_q)
		else $error("read data differs from live status word");

	c_poison_then_clear: cover property (
		poisoned_tlp_rx ##[1:20] wr_one[FLG_DET_POISON]);
	c_set_clear_same: cover property (
		cpl_ur_rx && wr_one[FLG_RX_UR]);
	c_gated_message: cover property (
		err_msg_tx && !system_error_enable);
	c_read_all_flags: cover property (
		cfg_rd_valid_q && cfg_rd_data_q == 16'hf910);
	c_unmapped_read: cover property (
		cfg_rd_en && !hit_status);

endmodule // bpsr_status_top

/* File: bench/bpsr_host_model.sv */
// Purpose: upstream configuration master for the primary status word
// Assumes: requests change 1 ns after the rising edge, one at a time
// Notes:   idle address and data carry the inverse of the last value
`timescale 1ns/100ps
module bpsr_host_model
	import bpsr_pkg::*;
(
	// clock
	input  wire logic                   clock,
	// configuration request
	output logic                        cfg_rd_en,
	output logic                        cfg_wr_en,
	output logic      [BPSR_ADDR_W-1:0] cfg_addr,
	output logic      [BPSR_DATA_W-1:0] cfg_wr_data,
	output logic      [BPSR_BE_W-1:0]   cfg_byte_en,
	// read answer
	input  wire logic [BPSR_DATA_W-1:0] cfg_rd_data_q,
	input  wire logic                   cfg_rd_valid_q
);
	// quiet bus at time zero
	initial begin
		cfg_rd_en   = 1'b0;
		cfg_wr_en   = 1'b0;
		cfg_addr    = 8'h00;
		cfg_wr_data = 16'h0000;
		cfg_byte_en = 2'h0;
	end

	// scrambled idle lines expose a design that samples outside a request
	task automatic idle();
		cfg_rd_en   = 1'b0;
		cfg_wr_en   = 1'b0;
		cfg_addr    = ~cfg_addr;
		cfg_wr_data = ~cfg_wr_data;
	endtask

	// one read; the answer stands for the cycle after the taking edge
	task automatic rd(input logic [BPSR_ADDR_W-1:0] a, output bpsr_word_t d, output logic v);
		@(posedge clock) #1;
		cfg_addr  = a;
		cfg_rd_en = 1'b1;
		@(posedge clock) #1;
		d = cfg_rd_data_q;
		v = cfg_rd_valid_q;
		idle();
	endtask

	// one write; a one in a flag bit clears that flag
	task automatic wr(input logic [BPSR_ADDR_W-1:0] a, input bpsr_word_t d,
		input logic [BPSR_BE_W-1:0] b);
		@(posedge clock) #1;
		cfg_addr    = a;
		cfg_wr_data = d;
		cfg_byte_en = b;
		cfg_wr_en   = 1'b1;
		@(posedge clock) #1;
		idle();
	endtask
endmodule // bpsr_host_model

/* File: bench/tb_bridge_primary_status_register.sv */
// Purpose: self-checking bench for the primary error status word
// Assumes: host model makes config accesses, bench drives event pulses
// Notes:   event order: tlp, msg, ur rx, ca rx, ca tx, cpl poison, wr poison
`timescale 1ns/100ps
module tb_bridge_primary_status_register;
	import bpsr_pkg::*;

	logic                   clock, rst_b, par_en, sys_en, rd_en, wr_en, rd_valid;
	logic [6:0]             ev;
	logic [BPSR_ADDR_W-1:0] addr;
	logic [BPSR_BE_W-1:0]   be;
	bpsr_word_t             wr_data, rd_data, status_word;
	int                     num_errors = 0;
	int                     total_checks = 0;
	// status bit set by each event, in event order
	int                     pos [7] = '{15, 14, 13, 12, 11, 8, 8};

	bpsr_host_model bpsr_host_model_i (.clock(clock), .cfg_rd_en(rd_en), .cfg_wr_en(wr_en),
		.cfg_addr(addr), .cfg_wr_data(wr_data), .cfg_byte_en(be),
		.cfg_rd_data_q(rd_data), .cfg_rd_valid_q(rd_valid));
	bpsr_status_top bpsr_status_top_i (.clock(clock), .rst_b(rst_b), .cfg_rd_en(rd_en),
		.cfg_wr_en(wr_en), .cfg_addr(addr), .cfg_wr_data(wr_data), .cfg_byte_en(be),
		.cfg_rd_data_q(rd_data), .cfg_rd_valid_q(rd_valid), .parity_response_enable(par_en),
		.system_error_enable(sys_en), .poisoned_tlp_rx(ev[0]), .err_msg_tx(ev[1]),
		.cpl_ur_rx(ev[2]), .cpl_ca_rx(ev[3]), .cpl_ca_tx(ev[4]), .cpl_poison_rx(ev[5]),
		.write_poisoned(ev[6]), .status_word_q(status_word));

	// 200 MHz core clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input bpsr_word_t got, input bpsr_word_t exp, input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// read and compare both the answer marker and the data
	task automatic rd_chk(input logic [BPSR_ADDR_W-1:0] a, input bpsr_word_t exp);
		bpsr_word_t d;
		logic       v;
		bpsr_host_model_i.rd(a, d, v);
		chk({15'h0000, v}, 16'h0001, "read valid");
		chk(d, exp, "read data");
	endtask

	// events are taken at the edge after they rise
	task automatic pulse(input logic [6:0] m);
		@(posedge clock) #1;
		ev = m;
		@(posedge clock) #1;
		ev = 7'h00;
	endtask

	// each event alone, then write-one clear; ones written to fixed bits must not stick
	task automatic t_events();
		par_en = 1'b1;
		sys_en = 1'b1;
		for (int i = 0; i < 7; i++) begin
			pulse(7'h01 << i);
			@(posedge clock) #1;
			chk(status_word, 16'h0010 | (16'h0001 << pos[i]), "live");
			rd_chk(8'h06, 16'h0010 | (16'h0001 << pos[i]));
			bpsr_host_model_i.wr(8'h06, 16'hffff, 2'h3);
			rd_chk(8'h06, 16'h0010);
		end
	endtask

	// enables gate only the message and data-poison events; bit 15 ignores both
	task automatic t_gating();
		par_en = 1'b0;
		sys_en = 1'b0;
		pulse(7'h7f);
		rd_chk(8'h06, 16'hb810);
		par_en = 1'b1;
		sys_en = 1'b1;
		pulse(7'h62);
		rd_chk(8'h06, 16'hf910);
	endtask

	// zero writes, a disabled lane and an unmapped offset leave the flags alone
	task automatic t_clear();
		bpsr_host_model_i.wr(8'h06, 16'h0000, 2'h3);
		bpsr_host_model_i.wr(8'h06, 16'hffff, 2'h1);
		bpsr_host_model_i.wr(8'h04, 16'hffff, 2'h3);
		rd_chk(8'h04, 16'h0000);
		rd_chk(8'h06, 16'hf910);
		bpsr_host_model_i.wr(8'h06, 16'h8000, 2'h2);
		rd_chk(8'h06, 16'h7910);
		bpsr_host_model_i.wr(8'h06, 16'hffff, 2'h2);
		rd_chk(8'h06, 16'h0010);
	endtask

	// clear and set of one flag in the same cycle keep the flag; reset clears it
	task automatic t_coincide();
		pulse(7'h04);
		fork
			bpsr_host_model_i.wr(8'h06, 16'h2000, 2'h2);
			pulse(7'h04);
		join
		rd_chk(8'h06, 16'h2010);
		rst_b = 1'b0;
		#1;
		chk(status_word, 16'h0010, "reset");
		@(posedge clock) #1;
		rst_b = 1'b1;
		rd_chk(8'h06, 16'h0010);
	endtask

	initial begin
		rst_b  = 1'b0;
		par_en = 1'b0;
		sys_en = 1'b0;
		ev     = 7'h00;
		repeat (2) @(posedge clock);
		#1;
		rst_b = 1'b1;
		chk(status_word, 16'h0010, "reset value");
		t_events();
		t_gating();
		t_clear();
		t_coincide();
		summarize();
	end
endmodule // tb_bridge_primary_status_register
